// *** shared/lair_pkg.sv ***
// What this block does
// - The signal-loss status register shows a one in bit n while channel n reports loss of signal.
// - The driver-fault status register shows a one in bit n while the driver monitor of channel n sees a short.
// - Every register of the group holds zero after power-up or any reset.
// - A change of a signal-loss status bit whose enable bit is one drives the low-active interrupt low.
// - A change of a driver-fault status bit whose enable bit is one raises the interrupt.
// - Bit n of the signal-loss change register is set when signal-loss status bit n changes either way.
// - Signal-loss change bits stay set until the signal-loss change register is read or ones are written to them.
// - Bit n of the driver-fault change register is set when driver-fault status bit n changes.
// - Driver-fault change bits stay set until the driver-fault change register is read or ones are written to them.
// - Any write to the software reset register returns every register to its default.
// - The line monitor is routed to the path chosen by the low four bits of monitor select.
package lair_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CHAN_N = 8;
  localparam int IDX_W = 6;
  localparam int IDX_LSB = 2;
  localparam int SEL_W = 4;
  localparam int MON_CH_W = 3;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_SIGNAL_LOSS_STATUS = 6'h04;
  localparam logic [IDX_W-1:0] IDX_DRIVER_FAULT_STATUS = 6'h05;
  localparam logic [IDX_W-1:0] IDX_SIGNAL_LOSS_IRQ_ENABLE = 6'h06;
  localparam logic [IDX_W-1:0] IDX_DRIVER_FAULT_IRQ_ENABLE = 6'h07;
  localparam logic [IDX_W-1:0] IDX_SIGNAL_LOSS_CHANGE = 6'h08;
  localparam logic [IDX_W-1:0] IDX_DRIVER_FAULT_CHANGE = 6'h09;
  localparam logic [IDX_W-1:0] IDX_SOFT_RESET = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_MONITOR_SELECT = 6'h0b;

  localparam logic [CHAN_N-1:0] REG_RESET = 8'h00;
  localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [SEL_W-1:0] SEL_OFF_LOW = 4'h0;
  localparam logic [SEL_W-1:0] SEL_OFF_HIGH = 4'h8;
  localparam int SEL_TX_BIT = 3;

  typedef enum logic [1:0] {
    LAIR_MON_OFF,
    LAIR_MON_RX,
    LAIR_MON_TX
  } lair_mon_path_t;

endpackage : lair_pkg

// *** verilog/lair_regs.sv ***
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
module lair_regs (
  input wire logic clk_sys,
  input wire logic resetn,
  // AXI4-Lite write address channel.
  input wire logic [lair_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel.
  input wire logic [lair_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel.
  input wire logic [lair_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [lair_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Per-channel detector levels from the line side, asynchronous.
  input wire logic [lair_pkg::CHAN_N-1:0] signal_loss,
  input wire logic [lair_pkg::CHAN_N-1:0] driver_fault_monitor,
  // Interrupt outputs.
  output logic int_n,
  output logic irq,
  // Line monitor routing.
  output logic monitor_enable,
  output logic monitor_tx,
  output logic [lair_pkg::MON_CH_W-1:0] monitor_channel
);

  // ==========================================================================
  // Decode helpers
  // ==========================================================================

  function automatic logic [lair_pkg::IDX_W-1:0] lair_index(
    input logic [lair_pkg::ADDR_W-1:0] addr
  );
    lair_index = addr[lair_pkg::ADDR_W-1:lair_pkg::IDX_LSB];
  endfunction : lair_index

  function automatic logic lair_mapped(
    input logic [lair_pkg::IDX_W-1:0] idx
  );
    lair_mapped = (idx >= lair_pkg::IDX_SIGNAL_LOSS_STATUS) &&
                  (idx <= lair_pkg::IDX_MONITOR_SELECT);
  endfunction : lair_mapped

  function automatic lair_pkg::lair_mon_path_t lair_mon_path(
    input logic [lair_pkg::SEL_W-1:0] sel
  );
    if ((sel == lair_pkg::SEL_OFF_LOW) || (sel == lair_pkg::SEL_OFF_HIGH)) begin
      lair_mon_path = lair_pkg::LAIR_MON_OFF;
    end else if (sel[lair_pkg::SEL_TX_BIT]) begin
      lair_mon_path = lair_pkg::LAIR_MON_TX;
    end else begin
      lair_mon_path = lair_pkg::LAIR_MON_RX;
    end
  endfunction : lair_mon_path

  // ==========================================================================
  // Register state
  // ==========================================================================

  logic [lair_pkg::CHAN_N-1:0] loss_meta;
  logic [lair_pkg::CHAN_N-1:0] fault_meta;
  logic [lair_pkg::CHAN_N-1:0] signal_loss_status;
  logic [lair_pkg::CHAN_N-1:0] driver_fault_status;
  logic [lair_pkg::CHAN_N-1:0] loss_prev;
  logic [lair_pkg::CHAN_N-1:0] fault_prev;
  logic [lair_pkg::CHAN_N-1:0] signal_loss_irq_enable;
  logic [lair_pkg::CHAN_N-1:0] driver_fault_irq_enable;
  logic [lair_pkg::CHAN_N-1:0] signal_loss_change;
  logic [lair_pkg::CHAN_N-1:0] driver_fault_change;
  logic [lair_pkg::SEL_W-1:0] monitor_select;

  logic [lair_pkg::ADDR_W-1:0] wr_addr;
  logic [lair_pkg::DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic soft_reset_hit;
  logic lane0_write;
  logic [lair_pkg::IDX_W-1:0] wr_idx;
  logic [lair_pkg::IDX_W-1:0] rd_idx;
  logic [lair_pkg::CHAN_N-1:0] loss_set;
  logic [lair_pkg::CHAN_N-1:0] fault_set;
  logic [lair_pkg::CHAN_N-1:0] loss_clr;
  logic [lair_pkg::CHAN_N-1:0] fault_clr;
  logic [lair_pkg::CHAN_N-1:0] next_signal_loss_change;
  logic [lair_pkg::CHAN_N-1:0] next_driver_fault_change;
  logic next_irq;
  lair_pkg::lair_mon_path_t mon_path;

  // ==========================================================================
  // AXI4-Lite handshakes
  // ==========================================================================

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // Both halves of a write are held once their ready has dropped. The write is
  // performed in the single cycle after the later half is taken and before the
  // response is raised, so each accepted write acts exactly once.
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_idx = lair_index(wr_addr);
  assign rd_idx = lair_index(s_axi_araddr);
  assign lane0_write = do_write && wr_strb[0];

  // A write of any value or strobe pattern counts as a software reset.
  assign soft_reset_hit = do_write && (wr_idx == lair_pkg::IDX_SOFT_RESET);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      wr_addr <= '0;
    end else if (aw_take) begin
      s_axi_awready <= 1'b0;
      wr_addr <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_wready <= 1'b1;
      wr_data <= lair_pkg::DATA_ZERO;
      wr_strb <= '0;
    end else if (w_take) begin
      s_axi_wready <= 1'b0;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // The response stays up until bready is seen; awready and wready return on that
  // same edge, so a new write is taken no sooner than the edge after it.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lair_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= lair_mapped(wr_idx) ? lair_pkg::RESP_OKAY : lair_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data is captured at the address handshake. A change register therefore
  // returns its bits as they stood before the clear that this handshake causes.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= lair_pkg::RESP_OKAY;
      s_axi_rdata <= lair_pkg::DATA_ZERO;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= lair_mapped(rd_idx) ? lair_pkg::RESP_OKAY : lair_pkg::RESP_SLVERR;
      s_axi_rdata <= lair_pkg::DATA_ZERO;
      unique case (rd_idx)
        lair_pkg::IDX_SIGNAL_LOSS_STATUS: begin
          s_axi_rdata[lair_pkg::CHAN_N-1:0] <= signal_loss_status;
        end
        lair_pkg::IDX_DRIVER_FAULT_STATUS: begin
          s_axi_rdata[lair_pkg::CHAN_N-1:0] <= driver_fault_status;
        end
        lair_pkg::IDX_SIGNAL_LOSS_IRQ_ENABLE: begin
          s_axi_rdata[lair_pkg::CHAN_N-1:0] <= signal_loss_irq_enable;
        end
        lair_pkg::IDX_DRIVER_FAULT_IRQ_ENABLE: begin
          s_axi_rdata[lair_pkg::CHAN_N-1:0] <= driver_fault_irq_enable;
        end
        lair_pkg::IDX_SIGNAL_LOSS_CHANGE: begin
          s_axi_rdata[lair_pkg::CHAN_N-1:0] <= signal_loss_change;
        end
        lair_pkg::IDX_DRIVER_FAULT_CHANGE: begin
          s_axi_rdata[lair_pkg::CHAN_N-1:0] <= driver_fault_change;
        end
        lair_pkg::IDX_MONITOR_SELECT: begin
          // Reserved upper bits are not stored and read back as zero.
          s_axi_rdata[lair_pkg::SEL_W-1:0] <= monitor_select;
        end
        default: begin
          s_axi_rdata <= lair_pkg::DATA_ZERO;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Detector synchronisers and status
  // ==========================================================================

  // The first stage is never cleared by software reset so it keeps filtering.
  // Only the second stage reads the first, so a metastable first stage never
  // fans out into the status or edge logic.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      loss_meta <= lair_pkg::REG_RESET;
      fault_meta <= lair_pkg::REG_RESET;
    end else begin
      loss_meta <= signal_loss;
      fault_meta <= driver_fault_monitor;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      signal_loss_status <= lair_pkg::REG_RESET;
      driver_fault_status <= lair_pkg::REG_RESET;
      loss_prev <= lair_pkg::REG_RESET;
      fault_prev <= lair_pkg::REG_RESET;
    end else if (soft_reset_hit) begin
      signal_loss_status <= lair_pkg::REG_RESET;
      driver_fault_status <= lair_pkg::REG_RESET;
      loss_prev <= lair_pkg::REG_RESET;
      fault_prev <= lair_pkg::REG_RESET;
    end else begin
      signal_loss_status <= loss_meta;
      driver_fault_status <= fault_meta;
      loss_prev <= signal_loss_status;
      fault_prev <= driver_fault_status;
    end
  end

  // ==========================================================================
  // Change registers
  // ==========================================================================

  // Clearing happens on the read handshake or by writing ones; a status edge
  // seen in the same cycle wins so that no event is lost.
  genvar ch;
  generate
    for (ch = 0; ch < lair_pkg::CHAN_N; ch = ch + 1) begin : g_change
      assign loss_set[ch] = signal_loss_status[ch] ^ loss_prev[ch];
      assign fault_set[ch] = driver_fault_status[ch] ^ fault_prev[ch];
      assign loss_clr[ch] = (ar_take && (rd_idx == lair_pkg::IDX_SIGNAL_LOSS_CHANGE)) ||
                            (lane0_write && (wr_idx == lair_pkg::IDX_SIGNAL_LOSS_CHANGE) &&
                             wr_data[ch]);
      assign fault_clr[ch] = (ar_take && (rd_idx == lair_pkg::IDX_DRIVER_FAULT_CHANGE)) ||
                             (lane0_write && (wr_idx == lair_pkg::IDX_DRIVER_FAULT_CHANGE) &&
                              wr_data[ch]);
      assign next_signal_loss_change[ch] = loss_set[ch] ||
                                           (signal_loss_change[ch] && !loss_clr[ch]);
      assign next_driver_fault_change[ch] = fault_set[ch] ||
                                            (driver_fault_change[ch] && !fault_clr[ch]);
    end
  endgenerate

  // After a software reset the status reloads from the synchroniser on the next
  // edge, so a detector that is still active shows up again as a change bit.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      signal_loss_change <= lair_pkg::REG_RESET;
      driver_fault_change <= lair_pkg::REG_RESET;
    end else if (soft_reset_hit) begin
      signal_loss_change <= lair_pkg::REG_RESET;
      driver_fault_change <= lair_pkg::REG_RESET;
    end else begin
      signal_loss_change <= next_signal_loss_change;
      driver_fault_change <= next_driver_fault_change;
    end
  end

  // ==========================================================================
  // Writable control registers
  // ==========================================================================

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      signal_loss_irq_enable <= lair_pkg::REG_RESET;
      driver_fault_irq_enable <= lair_pkg::REG_RESET;
    end else if (soft_reset_hit) begin
      signal_loss_irq_enable <= lair_pkg::REG_RESET;
      driver_fault_irq_enable <= lair_pkg::REG_RESET;
    end else if (lane0_write && (wr_idx == lair_pkg::IDX_SIGNAL_LOSS_IRQ_ENABLE)) begin
      signal_loss_irq_enable <= wr_data[lair_pkg::CHAN_N-1:0];
    end else if (lane0_write && (wr_idx == lair_pkg::IDX_DRIVER_FAULT_IRQ_ENABLE)) begin
      driver_fault_irq_enable <= wr_data[lair_pkg::CHAN_N-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      monitor_select <= lair_pkg::SEL_RESET;
    end else if (soft_reset_hit) begin
      monitor_select <= lair_pkg::SEL_RESET;
    end else if (lane0_write && (wr_idx == lair_pkg::IDX_MONITOR_SELECT)) begin
      // Only the selector nibble is kept; the host must leave the rest zero.
      monitor_select <= wr_data[lair_pkg::SEL_W-1:0];
    end
  end

  // ==========================================================================
  // Interrupt
  // ==========================================================================

  // The interrupt follows the change bits, not the status, so an alarm that comes
  // and goes between two polls is still reported until the host clears it.
  assign next_irq = |(signal_loss_change & signal_loss_irq_enable) ||
                    |(driver_fault_change & driver_fault_irq_enable);

  // Both pins are loaded from one value, so they never disagree and neither
  // glitches while change and enable bits move in the same cycle.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
      int_n <= 1'b1;
    end else begin
      irq <= next_irq;
      int_n <= !next_irq;
    end
  end

  // ==========================================================================
  // Line monitor routing
  // ==========================================================================

  // Select values 0 and 8 both park the monitor, so the channel field is
  // only meaningful while monitor_enable is high.
  assign mon_path = lair_mon_path(monitor_select);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      monitor_enable <= 1'b0;
      monitor_tx <= 1'b0;
      monitor_channel <= '0;
    end else begin
      unique case (mon_path)
        lair_pkg::LAIR_MON_OFF: begin
          monitor_enable <= 1'b0;
          monitor_tx <= 1'b0;
          monitor_channel <= '0;
        end
        lair_pkg::LAIR_MON_RX: begin
          monitor_enable <= 1'b1;
          monitor_tx <= 1'b0;
          monitor_channel <= monitor_select[lair_pkg::MON_CH_W-1:0];
        end
        lair_pkg::LAIR_MON_TX: begin
          monitor_enable <= 1'b1;
          monitor_tx <= 1'b1;
          monitor_channel <= monitor_select[lair_pkg::MON_CH_W-1:0];
        end
        // The fourth code of the path type is never produced; it parks the monitor.
        default: begin
          monitor_enable <= 1'b0;
          monitor_tx <= 1'b0;
          monitor_channel <= '0;
        end
      endcase
    end
  end

endmodule : lair_regs

// *** verification/lair_host.sv ***
`timescale 1ns/100ps
// ==========
// Host processor model on the register bus.
module lair_host (
  input wire logic clk_sys,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  output logic hung
);
  // Answers are awaited for a bounded time so that a dead slave ends the run.
  localparam int WAIT_MAX = 64;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
    int i;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < WAIT_MAX; i++) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    if (i == WAIT_MAX) hung <= 1'b1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < WAIT_MAX; i++) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (i == WAIT_MAX) hung <= 1'b1;
  endtask : rd
endmodule : lair_host

// *** verification/lair_regs_checker.sv ***
`timescale 1ns/100ps
// ==========
// Port checks of the alarm register block.
module lair_regs_checker (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic int_n,
  input wire logic irq,
  input wire logic monitor_enable,
  input wire logic monitor_tx,
  input wire logic [lair_pkg::MON_CH_W-1:0] monitor_channel
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_irq_pair;
    irq == !int_n;
  endproperty
  a_irq_pair: assert property (p_irq_pair) else $error("irq not inverse of int_n");
  property p_reset_quiet;
    $rose(resetn) |-> int_n && !monitor_enable && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  // A write in flight keeps wready low and a read answer keeps rvalid high, so
  // mask, clear and clear-on-read accesses leave the check vacuous.
  property p_int_sticky;
    !int_n && s_axi_wready && !s_axi_rvalid |=> !int_n;
  endproperty
  a_int_sticky: assert property (p_int_sticky) else $error("int_n released unasked");
  property p_mon_off;
    !monitor_enable |-> monitor_channel == '0 && !monitor_tx;
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("idle monitor shows a path");
  property p_mon_ch;
    monitor_enable |-> monitor_channel != '0;
  endproperty
  a_mon_ch: assert property (p_mon_ch) else $error("monitor on channel zero");
  property p_mon_write;
    // The outputs follow the select one edge after the write, while wready was still low.
    !$stable({monitor_enable, monitor_tx, monitor_channel}) |-> !$past(s_axi_wready);
  endproperty
  a_mon_write: assert property (p_mon_write) else $error("monitor moved without write");
  property p_write_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_write_lat: assert property (p_write_lat) else $error("write answer late");
  property p_read_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read answer late");
  c_int_low: cover property ($fell(int_n));
  c_tx_path: cover property (monitor_enable && monitor_tx);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == lair_pkg::RESP_SLVERR);
endmodule : lair_regs_checker
bind lair_regs lair_regs_checker u_checker (.*);

// *** verification/tb_lair_regs.sv ***
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", nm, e, s); end end
// ==========
// Register bench of the alarm block.
module tb_lair_regs;
  logic clk_sys, resetn, hung, int_n, irq, monitor_enable, monitor_tx;
  logic [7:0] signal_loss, driver_fault_monitor, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0] monitor_channel;
  int err_total = 0;
  int n_checks = 0;
  lair_regs DUT (.*);
  lair_host u_host (.*);
  task automatic end_of_test;
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    u_host.rd(a, d, r);
    `CHK("rdata", {24'h00_0000, e}, d)
    `CHK("rresp", er, r)
  endtask : rchk
  task automatic wchk(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    logic [1:0] r;
    u_host.wr(a, v, r);
    `CHK("bresp", er, r)
  endtask : wchk
  // Detector edges need four edges to reach int_n; one spare edge is allowed.
  task automatic drv(input int g, input logic [7:0] v);
    @(posedge clk_sys);
    if (g == 0) signal_loss <= v;
    else driver_fault_monitor <= v;
    repeat (5) @(posedge clk_sys);
  endtask : drv
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge hung) begin
    err_total++;
    end_of_test;
  end
  initial begin
    int g;
    int i;
    logic [7:0] b;
    logic [3:0] s;
    logic [4:0] m;
    resetn = 1'b0;
    signal_loss = 8'h00;
    driver_fault_monitor = 8'h00;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    `CHK("int_n", 1'b1, int_n)
    for (i = 4; i < 12; i++) rchk(8'(i * 4), 8'h00, lair_pkg::RESP_OKAY);
    for (g = 0; g < 2; g++) begin
      b = 8'(g * 4);
      wchk(8'h18 + b, 8'h81, lair_pkg::RESP_OKAY);
      drv(g, 8'h83);
      `CHK("int_n", 1'b0, int_n)
      rchk(8'h10 + b, 8'h83, lair_pkg::RESP_OKAY);
      rchk(8'h20 + b, 8'h83, lair_pkg::RESP_OKAY);
      rchk(8'h20 + b, 8'h00, lair_pkg::RESP_OKAY);
      drv(g, 8'h87);
      `CHK("int_n", 1'b1, int_n)
      drv(g, 8'h00);
      `CHK("int_n", 1'b0, int_n)
      wchk(8'h18 + b, 8'h00, lair_pkg::RESP_OKAY);
      repeat (2) @(posedge clk_sys);
      `CHK("int_n", 1'b1, int_n)
      rchk(8'h20 + b, 8'h87, lair_pkg::RESP_OKAY);
    end
    for (i = 0; i < 16; i++) begin
      s = 4'(i);
      m = {s[2:0] != 3'h0, s[3] && s[2:0] != 3'h0, s[2:0]};
      wchk(8'h2C, {4'h0, s}, lair_pkg::RESP_OKAY);
      repeat (2) @(posedge clk_sys);
      `CHK("monitor", m, {monitor_enable, monitor_tx, monitor_channel})
      rchk(8'h2C, {4'h0, s}, lair_pkg::RESP_OKAY);
    end
    wchk(8'h18, 8'hFF, lair_pkg::RESP_OKAY);
    drv(0, 8'h01);
    drv(0, 8'h00);
    `CHK("int_n", 1'b0, int_n)
    wchk(8'h28, 8'h5A, lair_pkg::RESP_OKAY);
    for (i = 4; i < 12; i++) rchk(8'(i * 4), 8'h00, lair_pkg::RESP_OKAY);
    `CHK("monitor_enable", 1'b0, monitor_enable)
    `CHK("int_n", 1'b1, int_n)
    rchk(8'h00, 8'h00, lair_pkg::RESP_SLVERR);
    wchk(8'h3C, 8'h01, lair_pkg::RESP_SLVERR);
    wchk(8'h10, 8'hFF, lair_pkg::RESP_OKAY);
    rchk(8'h10, 8'h00, lair_pkg::RESP_OKAY);
    end_of_test;
  end
endmodule : tb_lair_regs
